// ### core/word_data_format_unpacker.sv
`timescale 1ns/100ps
`default_nettype none
module word_data_format_unpacker
  import word_format_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire data_format_e format_sel,
  input  wire word_group_s  words_in,
  input  wire logic         make_true,
  output var  unpacked_s    result_q,
  output var  logic [15:0]  logic_word_q
);

  unpacked_s result_d;
  logic      flt_zero;
  logic      is_long;

  // Sign, first word bit 0 in big-endian numbering
  function automatic logic word_sign(input logic [15:0] w);
    word_sign = w[SIGN_POS];
  endfunction

  // Bits 1..9 of the first word
  function automatic logic [8:0] word_exp(input logic [15:0] w);
    word_exp = w[EXP_HI:EXP_LO];
  endfunction

  assign is_long = (format_sel == FMT_LONG);

  always_comb
  begin
    if (is_long)
      flt_zero = (words_in == '0);
    else
      flt_zero = ({words_in.w0, words_in.w1} == 32'h0000_0000);
  end

  always_comb
  begin
    result_d = '0;
    case (format_sel)
      FMT_INT:
      begin
        result_d.sign      = word_sign(words_in.w0);
        result_d.int_value = {{16{words_in.w0[SIGN_POS]}}, words_in.w0};
        result_d.is_zero   = (words_in.w0 == WORD_FALSE);
      end
      FMT_DINT:
      begin
        result_d.sign      = word_sign(words_in.w0);
        result_d.int_value = {words_in.w0, words_in.w1};
        result_d.is_zero   = ({words_in.w0, words_in.w1} == 32'h0000_0000);
      end
      FMT_REAL, FMT_LONG:
      begin
        result_d.sign       = word_sign(words_in.w0);
        result_d.exp_biased = word_exp(words_in.w0);
        result_d.exp_true   = $signed({1'b0, word_exp(words_in.w0)}) - $signed(EXP_BIAS);
        result_d.is_zero    = flt_zero;
        if (is_long)
          result_d.fraction = {~flt_zero, words_in.w0[FRAC_HI:0], words_in.w1, words_in.w2, words_in.w3};
        else
          result_d.fraction = {~flt_zero, words_in.w0[FRAC_HI:0], words_in.w1, 32'h0000_0000};
        if (is_long)
          result_d.negated = {~words_in.w0[SIGN_POS], words_in.w0[EXP_HI:0], words_in.w1, words_in.w2, words_in.w3};
        else
          result_d.negated = {~words_in.w0[SIGN_POS], words_in.w0[EXP_HI:0], words_in.w1, 32'h0000_0000};
      end
      FMT_BYTE:
      begin
        result_d.char_first  = words_in.w0[15:8];
        result_d.char_second = words_in.w0[7:0];
      end
      FMT_LOGIC:
      begin
        result_d.int_value = {16'h0000, words_in.w0};
        result_d.truth     = words_in.w0[0];
        result_d.is_zero   = (words_in.w0 == WORD_FALSE);
      end
      default:
        result_d = '0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      result_q <= '0;
    else
      result_q <= result_d;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      logic_word_q <= WORD_RST;
    else
      logic_word_q <= make_true ? WORD_TRUE : WORD_FALSE;
  end

  chk_latency_one: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_DINT |=> result_q.int_value == $past({words_in.w0, words_in.w1}))
    else $error("unpack latency wrong");

  chk_reset_clear: assert property (@(posedge clk_sys)
    rst |=> result_q == '0 && logic_word_q == WORD_RST)
    else $error("reset left outputs set");

  chk_undef_zero: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel > FMT_LOGIC |=> result_q == '0)
    else $error("undefined format not cleared");

  chk_int_zero: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_INT |=> result_q.is_zero == ($past(words_in.w0) == WORD_FALSE))
    else $error("int zero flag wrong");

  chk_int_sign: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_INT |=> result_q.sign == $past(words_in.w0[SIGN_POS])
      && result_q.sign == result_q.int_value[31])
    else $error("int sign wrong");

  chk_int_extend: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_INT |=> result_q.int_value == {{16{$past(words_in.w0[SIGN_POS])}}, $past(words_in.w0)})
    else $error("int extension wrong");

  chk_int_range: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_INT |=> $signed(result_q.int_value) >= -32768 && $signed(result_q.int_value) <= 32767)
    else $error("int out of range");

  chk_dint_sign: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_DINT |=> result_q.sign == $past(words_in.w0[SIGN_POS])
      && result_q.sign == result_q.int_value[31])
    else $error("double sign wrong");

  chk_dint_zero: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_DINT |=> result_q.is_zero == ($past({words_in.w0, words_in.w1}) == 32'h0000_0000))
    else $error("double zero flag wrong");

  chk_dint_range: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_DINT |=> ($signed(result_q.int_value) < 0) == result_q.sign)
    else $error("double value sign wrong");

  chk_real_sign: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_REAL |=> result_q.sign == $past(words_in.w0[SIGN_POS]))
    else $error("real sign wrong");

  chk_float_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (format_sel == FMT_REAL || format_sel == FMT_LONG) |=> result_q.int_value == 32'h0000_0000
      && !result_q.truth && result_q.char_first == 8'h00)
    else $error("float touched other fields");

  chk_exp_bias: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_REAL |=> result_q.exp_true == $signed({1'b0, $past(words_in.w0[14:6])}) - 10'sd256)
    else $error("exponent bias wrong");

  chk_exp_real_field: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_REAL |=> result_q.exp_biased == $past(words_in.w0[EXP_HI:EXP_LO]))
    else $error("real exponent field wrong");

  chk_exp_long: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_LONG |=> result_q.exp_biased == $past(words_in.w0[EXP_HI:EXP_LO])
      && result_q.exp_true == $signed({1'b0, $past(words_in.w0[EXP_HI:EXP_LO])}) - 10'sd256)
    else $error("long exponent wrong");

  chk_real_frac: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_REAL |=> result_q.fraction[53:0] == {$past(words_in.w0[FRAC_HI:0]),
      $past(words_in.w1), 32'h0000_0000})
    else $error("real fraction wrong");

  chk_real_zero: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_REAL |=> result_q.is_zero == ($past({words_in.w0, words_in.w1}) == 32'h0000_0000))
    else $error("real zero detect wrong");

  chk_zero_frac: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_REAL && {words_in.w0, words_in.w1} == 32'h0000_0000 |=> result_q.fraction == '0
      && result_q.exp_true == -10'sd256)
    else $error("real zero fraction wrong");

  chk_negate_sign: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_LONG |=> result_q.negated == ($past(words_in) ^ 64'h8000_0000_0000_0000))
    else $error("negate changed more than sign");

  chk_real_negate: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_REAL |=> result_q.negated == {$past(words_in.w0) ^ 16'h8000,
      $past(words_in.w1), 32'h0000_0000})
    else $error("real negate wrong");

  chk_long_sign: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_LONG |=> result_q.sign == $past(words_in.w0[SIGN_POS]))
    else $error("long sign wrong");

  chk_long_frac: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_LONG |=> result_q.fraction[53:0] == {$past(words_in.w0[FRAC_HI:0]),
      $past(words_in.w1), $past(words_in.w2), $past(words_in.w3)})
    else $error("long fraction wrong");

  chk_hidden_one: assert property (@(posedge clk_sys) disable iff (rst)
    (format_sel == FMT_LONG || format_sel == FMT_REAL) |=> result_q.fraction[54] == !result_q.is_zero)
    else $error("hidden one wrong");

  chk_long_zero: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_LONG |=> result_q.is_zero == ($past(words_in) == 64'h0000_0000_0000_0000))
    else $error("long zero detect wrong");

  chk_long_zero_frac: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_LONG && words_in == '0 |=> result_q.fraction == '0)
    else $error("long zero fraction wrong");

  chk_char_order: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_BYTE |=> result_q.char_first == $past(words_in.w0[15:8]))
    else $error("char order wrong");

  chk_char_second: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_BYTE |=> result_q.char_second == $past(words_in.w0[7:0]))
    else $error("second char wrong");

  chk_byte_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_BYTE |=> result_q.fraction == '0 && result_q.int_value == 32'h0000_0000)
    else $error("byte touched other fields");

  chk_logic_value: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_LOGIC |=> result_q.int_value == {16'h0000, $past(words_in.w0)})
    else $error("logical value wrong");

  chk_logic_unsigned: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_LOGIC |=> !result_q.sign && result_q.is_zero == ($past(words_in.w0) == WORD_FALSE))
    else $error("logical sign or zero wrong");

  chk_logic_truth: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_LOGIC |=> result_q.truth == $past(words_in.w0[0]))
    else $error("truth bit wrong");

  chk_truth_low: assert property (@(posedge clk_sys) disable iff (rst)
    format_sel == FMT_LOGIC && words_in.w0 == 16'hFFFE |=> !result_q.truth)
    else $error("even word read as true");

  chk_true_word: assert property (@(posedge clk_sys) disable iff (rst)
    make_true |=> logic_word_q == WORD_TRUE)
    else $error("TRUE word wrong");

  chk_false_word: assert property (@(posedge clk_sys) disable iff (rst)
    !make_true |=> logic_word_q == WORD_FALSE)
    else $error("FALSE word wrong");

endmodule // word_data_format_unpacker
`default_nettype wire

// ### pkg/word_format_pkg.sv
`default_nettype none
package word_format_pkg;

  localparam int WORD_W      = 16;
  localparam int EXP_W       = 9;
  localparam int REAL_FRAC_W = 22;
  localparam int LONG_FRAC_W = 54;
  localparam int CHAR_W      = 8;

  // Bit 0 is the leftmost (MSB) bit of a word
  localparam int SIGN_POS    = 15;
  localparam int EXP_HI      = 14;
  localparam int EXP_LO      = 6;
  localparam int FRAC_HI     = 5;

  localparam logic [9:0]  EXP_BIAS   = 10'h0100;
  localparam logic [15:0] WORD_TRUE  = 16'hFFFF;
  localparam logic [15:0] WORD_FALSE = 16'h0000;
  localparam logic [15:0] WORD_RST   = 16'h0000;

  typedef enum logic [2:0] {
    FMT_INT,
    FMT_DINT,
    FMT_REAL,
    FMT_LONG,
    FMT_BYTE,
    FMT_LOGIC
  } data_format_e;

  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] w3;
  } word_group_s;

  typedef struct packed {
    logic        sign;
    logic [8:0]  exp_biased;
    logic signed [9:0] exp_true;
    logic [54:0] fraction;
    logic        is_zero;
    logic signed [31:0] int_value;
    logic        truth;
    logic [7:0]  char_first;
    logic [7:0]  char_second;
    logic [63:0] negated;
  } unpacked_s;

endpackage
`default_nettype wire

// ### sim/word_source.sv
`timescale 1ns/100ps
`default_nettype none
module word_source
  import word_format_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire data_format_e fmt_req,
  input  wire word_group_s  words_req,
  input  wire logic         true_req,
  output var  data_format_e format_sel,
  output var  word_group_s  words_in,
  output var  logic         make_true
);
  // Launch just after the edge, clear of sampling
  always @(posedge clk_sys)
  begin
    #1;
    format_sel <= fmt_req;
    words_in   <= words_req;
    make_true  <= true_req;
  end
endmodule // word_source
`default_nettype wire

// ### sim/word_data_format_unpacker_bench.sv
`timescale 1ns/100ps
`default_nettype none
module word_data_format_unpacker_bench;
  import word_format_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rst     = 1'b1;
  data_format_e fmt_req = FMT_INT;
  word_group_s  words_req = '0;
  logic         true_req = 1'b0;
  data_format_e format_sel;
  word_group_s  words_in;
  logic         make_true;
  unpacked_s    res;
  unpacked_s    res_idle = '0;
  logic [15:0]  logic_q;
  int           err_total = 0;
  int           compares = 0;
  int           cycles = 0;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  word_source word_source_i (.clk_sys(clk_sys), .fmt_req(fmt_req), .words_req(words_req),
    .true_req(true_req), .format_sel(format_sel), .words_in(words_in), .make_true(make_true));
  word_data_format_unpacker word_data_format_unpacker_i (.clk_sys(clk_sys), .rst(rst),
    .format_sel(format_sel), .words_in(words_in), .make_true(make_true),
    .result_q(res), .logic_word_q(logic_q));
  // Launched one edge, registered the next
  task apply(input data_format_e f, input word_group_s w, input logic t);
    fmt_req = f;
    words_req = w;
    true_req = t;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #2;
  endtask
  task t_real;
    apply(FMT_REAL, {16'h40B0, 48'h0}, 1'b1);
    `CHK(res.sign, 1'b0)
    `CHK(res.exp_biased, 9'h102)
    `CHK(res.exp_true, 10'h002)
    `CHK(res.fraction, {1'b1, 6'h30, 48'h0})
    `CHK(res.negated, {16'hC0B0, 48'h0})
    `CHK(logic_q, WORD_TRUE)
    apply(FMT_REAL, {16'h0000, 16'h0001, 32'hFFFF_FFFF}, 1'b0);
    `CHK(res.exp_true, 10'h300)
    `CHK(res.is_zero, 1'b0)
    `CHK(res.fraction, {1'b1, 22'h1, 32'h0})
    `CHK(res.negated, {16'h8000, 16'h0001, 32'h0})
    apply(FMT_REAL, {32'h0, 32'hFFFF_FFFF}, 1'b0);
    `CHK(res.is_zero, 1'b1)
    `CHK(res.fraction, 55'h0)
  endtask
  task t_long;
    apply(FMT_LONG, {16'hFFFF, 16'h1234, 16'h5678, 16'h9ABC}, 1'b0);
    `CHK(res.sign, 1'b1)
    `CHK(res.exp_true, 10'h0FF)
    `CHK(res.fraction, {1'b1, 6'h3F, 48'h1234_5678_9ABC})
    `CHK(res.negated, {16'h7FFF, 48'h1234_5678_9ABC})
    apply(FMT_LONG, {48'h0, 16'h0001}, 1'b0);
    `CHK(res.is_zero, 1'b0)
    `CHK(res.fraction, {1'b1, 54'h1})
    apply(FMT_LONG, 64'h0, 1'b0);
    `CHK(res.is_zero, 1'b1)
    `CHK(res.fraction, 55'h0)
  endtask
  task t_int;
    apply(FMT_INT, {16'h8000, 48'hFFFF_FFFF_FFFF}, 1'b0);
    `CHK(res.sign, 1'b1)
    `CHK(res.int_value, 32'hFFFF_8000)
    apply(FMT_INT, {16'h7FFF, 48'hFFFF_FFFF_FFFF}, 1'b0);
    `CHK(res.int_value, 32'h0000_7FFF)
    apply(FMT_DINT, {16'h8000, 48'h0}, 1'b0);
    `CHK(res.int_value, 32'h8000_0000)
    apply(FMT_DINT, {32'h7FFF_FFFF, 32'hFFFF_FFFF}, 1'b0);
    `CHK(res.int_value, 32'h7FFF_FFFF)
  endtask
  task t_byte_logic;
    apply(FMT_BYTE, {16'h4142, 48'h0}, 1'b1);
    `CHK(res.char_first, 8'h41)
    `CHK(res.char_second, 8'h42)
    apply(FMT_LOGIC, {16'hFFFE, 48'h0}, 1'b0);
    `CHK(res.truth, 1'b0)
    `CHK(res.int_value, 32'h0000_FFFE)
    `CHK(logic_q, WORD_FALSE)
    apply(FMT_LOGIC, {16'h0001, 48'h0}, 1'b0);
    `CHK(res.truth, 1'b1)
  endtask
  // Reset in mid-run wins over held requests
  task t_reset;
    apply(FMT_LONG, {16'hFFFF, 48'h1234_5678_9ABC}, 1'b1);
    @(posedge clk_sys);
    #1 rst = 1'b1;
    #1;
    `CHK(res, res_idle)
    `CHK(logic_q, WORD_RST)
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    #1;
    `CHK(res, res_idle)
    apply(FMT_REAL, {16'h40B0, 48'h0}, 1'b0);
    `CHK(res.exp_true, 10'h002)
    `CHK(logic_q, WORD_FALSE)
  endtask
  task t_undef;
    apply(data_format_e'(3'h6), {16'hFFFF, 48'hFFFF_FFFF_FFFF}, 1'b0);
    `CHK(res, res_idle)
    apply(data_format_e'(3'h7), {16'h8001, 48'h0}, 1'b0);
    `CHK(res, res_idle)
  endtask
  task results;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Whole run needs about 60 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_total++;
      results;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'b0;
    #1;
    t_real;
    t_long;
    t_int;
    t_byte_logic;
    t_reset;
    t_undef;
    results;
  end
endmodule // word_data_format_unpacker_bench
`default_nettype wire
